// [hw/cbt_core.sv]
`timescale 1ns/10ps
`default_nettype none

module cbt_core
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Program memory
  output logic      [15:0]            pm_addr,
  output logic                        pm_rd,
  input  wire logic [7:0]             pm_data,
  // Datapath operands
  input  wire logic [7:0]             acc_data,
  input  wire logic                   carry_flag,
  input  wire logic                   bit_value,
  input  wire logic [7:0]             dir_rdata,
  input  wire logic [7:0]             ind0_rdata,
  input  wire logic [7:0]             ind1_rdata,
  // Datapath requests
  output logic      [7:0]             operand_addr,
  output logic                        bit_clr,
  output logic                        dir_wr,
  output logic      [7:0]             dir_wdata,
  // Status
  output cbt_pkg::cbt_mstate_type     machine_state,
  output logic      [7:0]             cur_opcode,
  output logic                        instr_done,
  output logic                        branch_taken
);

  typedef struct packed
  {
    cbt_pkg::cbt_mstate_type mst;
    logic [15:0]             pc;
    logic [7:0]              op;
    logic [7:0]              b1;
    logic [7:0]              b2;
    logic [1:0]              len;
    logic [2:0]              ncyc;
    logic [2:0]              k;
    logic                    done;
    logic                    taken;
    logic                    bclr;
    logic                    dwr;
    logic [7:0]              dwdata;
  } cbt_state_type;

  cbt_state_type st_reg;
  cbt_state_type st_next;

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  function automatic logic is_xmov(input logic [7:0] op);
    return op == cbt_pkg::OP_XMOV_0 || op == cbt_pkg::OP_XMOV_1 ||
           op == cbt_pkg::OP_XMOV_2 || op == cbt_pkg::OP_XMOV_3 ||
           op == cbt_pkg::OP_XMOV_4 || op == cbt_pkg::OP_XMOV_5;
  endfunction

  function automatic logic [1:0] op_len(input logic [7:0] op);
    logic [1:0] l;
    l = cbt_pkg::LEN_2;
    if (op[3] || is_xmov(op))
    begin
      l = cbt_pkg::LEN_1;
    end
    case (op)
      cbt_pkg::OP_SHORT_JMP, cbt_pkg::OP_JMP_ACC_Z,
      cbt_pkg::OP_JMP_ACC_NZ, cbt_pkg::OP_JMP_CY,
      cbt_pkg::OP_JMP_NCY:                                  l = cbt_pkg::LEN_2;
      cbt_pkg::OP_JMP_BIT, cbt_pkg::OP_JMP_NBIT,
      cbt_pkg::OP_JMP_BIT_CLR:                              l = cbt_pkg::LEN_3;
      cbt_pkg::OP_CMP_ACC_DIR, cbt_pkg::OP_CMP_ACC_IMM:     l = cbt_pkg::LEN_3;
      cbt_pkg::OP_CMP_IND0, cbt_pkg::OP_CMP_IND1:           l = cbt_pkg::LEN_3;
      cbt_pkg::OP_DEC_DIR:                                  l = cbt_pkg::LEN_3;
      default:
      begin
        if (op[7:3] == cbt_pkg::OP_CMP_REG_HI)
        begin
          l = cbt_pkg::LEN_3;
        end
        if (op[7:3] == cbt_pkg::OP_DEC_REG_HI)
        begin
          l = cbt_pkg::LEN_2;
        end
      end
    endcase
    return l;
  endfunction

  function automatic logic is_branch(input logic [7:0] op);
    return op == cbt_pkg::OP_SHORT_JMP || op == cbt_pkg::OP_JMP_ACC_Z ||
           op == cbt_pkg::OP_JMP_ACC_NZ || op == cbt_pkg::OP_JMP_CY ||
           op == cbt_pkg::OP_JMP_NCY || op == cbt_pkg::OP_JMP_BIT ||
           op == cbt_pkg::OP_JMP_NBIT || op == cbt_pkg::OP_JMP_BIT_CLR ||
           op == cbt_pkg::OP_CMP_ACC_DIR || op == cbt_pkg::OP_CMP_ACC_IMM ||
           op == cbt_pkg::OP_CMP_IND0 || op == cbt_pkg::OP_CMP_IND1 ||
           op == cbt_pkg::OP_DEC_DIR || op[7:3] == cbt_pkg::OP_CMP_REG_HI ||
           op[7:3] == cbt_pkg::OP_DEC_REG_HI;
  endfunction

  // Branches take one machine cycle beyond their byte count
  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    logic [2:0] c;
    c = {1'b0, op_len(op)};
    if (is_branch(op))
    begin
      c = 3'({1'b0, op_len(op)} + cbt_pkg::MC_1);
    end
    if (is_xmov(op))
    begin
      c = cbt_pkg::MC_2;
    end
    return c;
  endfunction

  function automatic logic [15:0] rel_target(input logic [15:0] next_pc,
                                             input logic [7:0]  rel);
    return 16'(next_pc + {{8{rel[7]}}, rel});
  endfunction

  // ----------------------------------------
  // Working registers
  // ----------------------------------------
  logic [7:0] reg_rdata;
  logic       reg_wr;
  logic [7:0] reg_dec;

  cbt_reg_file u_regs
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .rd_addr (st_reg.op[cbt_pkg::REG_AW-1:0]),
    .rd_data (reg_rdata),
    .wr_en   (reg_wr),
    .wr_addr (st_reg.op[cbt_pkg::REG_AW-1:0]),
    .wr_data (reg_dec)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic       last_cyc;
  logic       cond;
  logic [7:0] dir_dec;
  logic [7:0] rel;
  logic [7:0] op_now;
  logic [1:0] len_now;
  logic [2:0] cyc_now;

  always_comb
  begin
    st_next  = st_reg;
    reg_wr   = 1'b0;
    reg_dec  = 8'(reg_rdata - cbt_pkg::BYTE_ONE);
    dir_dec  = 8'(dir_rdata - cbt_pkg::BYTE_ONE);
    op_now   = (st_reg.k == 3'd0) ? pm_data : st_reg.op;
    len_now  = (st_reg.k == 3'd0) ? op_len(pm_data) : st_reg.len;
    cyc_now  = (st_reg.k == 3'd0) ? op_cycles(pm_data) : st_reg.ncyc;
    last_cyc = 3'(st_reg.k + 3'd1) == cyc_now;
    rel      = (len_now == cbt_pkg::LEN_2) ? st_reg.b1 : st_reg.b2;
    cond     = 1'b0;
    st_next.done  = 1'b0;
    st_next.taken = 1'b0;
    st_next.bclr  = 1'b0;
    st_next.dwr   = 1'b0;

    // Four states per machine cycle, fixed order
    case (st_reg.mst)
      cbt_pkg::CBT_FIRST_MACHINE_STATE:  st_next.mst = cbt_pkg::CBT_SECOND_MACHINE_STATE;
      cbt_pkg::CBT_SECOND_MACHINE_STATE: st_next.mst = cbt_pkg::CBT_THIRD_MACHINE_STATE;
      cbt_pkg::CBT_THIRD_MACHINE_STATE:  st_next.mst = cbt_pkg::CBT_FOURTH_MACHINE_STATE;
      cbt_pkg::CBT_FOURTH_MACHINE_STATE: st_next.mst = cbt_pkg::CBT_FIRST_MACHINE_STATE;
      default:                           st_next.mst = cbt_pkg::CBT_FIRST_MACHINE_STATE;
    endcase

    // Branch condition
    case (op_now)
      cbt_pkg::OP_SHORT_JMP:   cond = 1'b1;
      cbt_pkg::OP_JMP_ACC_Z:   cond = acc_data == cbt_pkg::BYTE_ZERO;
      cbt_pkg::OP_JMP_ACC_NZ:  cond = acc_data != cbt_pkg::BYTE_ZERO;
      cbt_pkg::OP_JMP_CY:      cond = carry_flag;
      cbt_pkg::OP_JMP_NCY:     cond = !carry_flag;
      cbt_pkg::OP_JMP_BIT:     cond = bit_value;
      cbt_pkg::OP_JMP_NBIT:    cond = !bit_value;
      cbt_pkg::OP_JMP_BIT_CLR: cond = bit_value;
      cbt_pkg::OP_CMP_ACC_DIR: cond = acc_data != dir_rdata;
      cbt_pkg::OP_CMP_ACC_IMM: cond = acc_data != st_reg.b1;
      cbt_pkg::OP_CMP_IND0:    cond = ind0_rdata != st_reg.b1;
      cbt_pkg::OP_CMP_IND1:    cond = ind1_rdata != st_reg.b1;
      cbt_pkg::OP_DEC_DIR:     cond = dir_dec != cbt_pkg::BYTE_ZERO;
      default:
      begin
        if (op_now[7:3] == cbt_pkg::OP_CMP_REG_HI)
        begin
          cond = reg_rdata != st_reg.b1;
        end
        if (op_now[7:3] == cbt_pkg::OP_DEC_REG_HI)
        begin
          cond = reg_dec != cbt_pkg::BYTE_ZERO;
        end
      end
    endcase

    // Byte taken and cycle closed in the fourth state
    if (st_reg.mst == cbt_pkg::CBT_FOURTH_MACHINE_STATE)
    begin
      if (st_reg.k == 3'd0)
      begin
        st_next.op   = pm_data;
        st_next.len  = len_now;
        st_next.ncyc = cyc_now;
      end
      if (st_reg.k == 3'd1)
      begin
        st_next.b1 = pm_data;
      end
      if (st_reg.k == 3'd2)
      begin
        st_next.b2 = pm_data;
      end
      if (st_reg.k < {1'b0, len_now})
      begin
        st_next.pc = 16'(st_reg.pc + cbt_pkg::PC_ONE);
      end
      st_next.k = 3'(st_reg.k + 3'd1);
      if (last_cyc)
      begin
        st_next.k    = 3'd0;
        st_next.done = 1'b1;
        if (is_branch(op_now))
        begin
          st_next.taken = cond;
          if (cond)
          begin
            st_next.pc = rel_target(st_reg.pc, rel);
          end
          if (op_now == cbt_pkg::OP_JMP_BIT_CLR && cond)
          begin
            st_next.bclr = 1'b1;
          end
          if (op_now == cbt_pkg::OP_DEC_DIR)
          begin
            st_next.dwr    = 1'b1;
            st_next.dwdata = dir_dec;
          end
          if (op_now[7:3] == cbt_pkg::OP_DEC_REG_HI)
          begin
            reg_wr = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '{mst: cbt_pkg::CBT_FIRST_MACHINE_STATE, pc: cbt_pkg::PC_RESET,
                  op: cbt_pkg::BYTE_ZERO, b1: cbt_pkg::BYTE_ZERO,
                  b2: cbt_pkg::BYTE_ZERO, len: cbt_pkg::LEN_1,
                  ncyc: cbt_pkg::MC_1, k: 3'd0, done: 1'b0, taken: 1'b0,
                  bclr: 1'b0, dwr: 1'b0, dwdata: cbt_pkg::BYTE_ZERO};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pm_addr       = st_reg.pc;
  assign pm_rd         = st_reg.mst == cbt_pkg::CBT_FIRST_MACHINE_STATE &&
                         st_reg.k < {1'b0, (st_reg.k == 3'd0) ? cbt_pkg::LEN_3 : st_reg.len};
  assign operand_addr  = st_reg.b1;
  assign bit_clr       = st_reg.bclr;
  assign dir_wr        = st_reg.dwr;
  assign dir_wdata     = st_reg.dwdata;
  assign machine_state = st_reg.mst;
  assign cur_opcode    = st_reg.op;
  assign instr_done    = st_reg.done;
  assign branch_taken  = st_reg.taken;

endmodule

`default_nettype wire

// [inc/cbt_pkg.sv]
`default_nettype none

package cbt_pkg;

  // ----------------------------------------
  // Machine cycle structure
  // ----------------------------------------
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned STATES_PER_MC  = 4;

  typedef enum logic [1:0]
  {
    CBT_FIRST_MACHINE_STATE,
    CBT_SECOND_MACHINE_STATE,
    CBT_THIRD_MACHINE_STATE,
    CBT_FOURTH_MACHINE_STATE
  } cbt_mstate_type;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned  PC_W       = 16;
  localparam logic [15:0]  PC_RESET   = 16'h0000;
  localparam logic [15:0]  PC_ONE     = 16'h0001;
  localparam logic [7:0]   BYTE_ZERO  = 8'h00;
  localparam logic [7:0]   BYTE_ONE   = 8'h01;

  // ----------------------------------------
  // Branch opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_SHORT_JMP    = 8'h80;
  localparam logic [7:0] OP_JMP_ACC_Z    = 8'h60;
  localparam logic [7:0] OP_JMP_ACC_NZ   = 8'h70;
  localparam logic [7:0] OP_JMP_CY       = 8'h40;
  localparam logic [7:0] OP_JMP_NCY      = 8'h50;
  localparam logic [7:0] OP_JMP_BIT      = 8'h20;
  localparam logic [7:0] OP_JMP_NBIT     = 8'h30;
  localparam logic [7:0] OP_JMP_BIT_CLR  = 8'h10;
  localparam logic [7:0] OP_CMP_ACC_DIR  = 8'hB5;
  localparam logic [7:0] OP_CMP_ACC_IMM  = 8'hB4;
  localparam logic [7:0] OP_CMP_IND0     = 8'hB6;
  localparam logic [7:0] OP_CMP_IND1     = 8'hB7;
  localparam logic [4:0] OP_CMP_REG_HI   = 5'h17;  // B8..BF
  localparam logic [4:0] OP_DEC_REG_HI   = 5'h1B;  // D8..DF
  localparam logic [7:0] OP_DEC_DIR      = 8'hD5;

  // External data moves: one byte, two machine cycles
  localparam logic [7:0] OP_XMOV_0 = 8'hE0;
  localparam logic [7:0] OP_XMOV_1 = 8'hE2;
  localparam logic [7:0] OP_XMOV_2 = 8'hE3;
  localparam logic [7:0] OP_XMOV_3 = 8'hF0;
  localparam logic [7:0] OP_XMOV_4 = 8'hF2;
  localparam logic [7:0] OP_XMOV_5 = 8'hF3;

  // Byte length and machine cycle counts
  localparam logic [1:0] LEN_1 = 2'd1;
  localparam logic [1:0] LEN_2 = 2'd2;
  localparam logic [1:0] LEN_3 = 2'd3;
  localparam logic [2:0] MC_1  = 3'd1;
  localparam logic [2:0] MC_2  = 3'd2;
  localparam logic [2:0] MC_3  = 3'd3;
  localparam logic [2:0] MC_4  = 3'd4;

  localparam int unsigned REG_CNT = 8;
  localparam int unsigned REG_AW  = 3;

endpackage

`default_nettype wire

// [hw/cbt_reg_file.sv]
`timescale 1ns/10ps
`default_nettype none

// Working register bank, registered read port
module cbt_reg_file
(
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           rst_n,
  // Read port
  input  wire logic [cbt_pkg::REG_AW-1:0]     rd_addr,
  output logic      [7:0]                     rd_data,
  // Write port
  input  wire logic                           wr_en,
  input  wire logic [cbt_pkg::REG_AW-1:0]     wr_addr,
  input  wire logic [7:0]                     wr_data
);

  logic [7:0] mem_reg [cbt_pkg::REG_CNT];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < cbt_pkg::REG_CNT; i++)
      begin
        mem_reg[i] <= cbt_pkg::BYTE_ZERO;
      end
      rd_data <= cbt_pkg::BYTE_ZERO;
    end
    else
    begin
      if (wr_en)
      begin
        mem_reg[wr_addr] <= wr_data;
      end
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule

`default_nettype wire

// [tb/cbt_core_properties.sv]
`timescale 1ns/10ps
`default_nettype none

module cbt_core_properties
(
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  // Program memory
  input wire logic [15:0]             pm_addr,
  input wire logic                    pm_rd,
  // Datapath
  input wire logic [7:0]              dir_rdata,
  input wire logic                    bit_clr,
  input wire logic                    dir_wr,
  input wire logic [7:0]              dir_wdata,
  // Status
  input wire cbt_pkg::cbt_mstate_type machine_state,
  input wire logic [7:0]              cur_opcode,
  input wire logic                    instr_done,
  input wire logic                    branch_taken
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic       st1;
  logic       op3;
  logic       op4;
  logic       opx;
  logic [4:0] gap_reg;
  assign st1 = machine_state == cbt_pkg::CBT_FIRST_MACHINE_STATE;
  assign op3 = cur_opcode inside {8'h80, 8'h60, 8'h70, 8'h40, 8'h50, [8'hD8:8'hDF]};
  assign op4 = cur_opcode inside {8'h20, 8'h30, 8'h10, [8'hB4:8'hBF], 8'hD5};
  assign opx = cur_opcode inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
  // Clocks since reset or since the last completed instruction
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      gap_reg <= 5'h00;
    else
      gap_reg <= instr_done ? 5'h01 : gap_reg + 5'h01;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_state_step; rst_n |=> 2'(machine_state) == 2'($past(machine_state)) + 2'h1; endproperty
  a_state_step: assert property (p_state_step) else $error("state order broken");
  property p_addr_hold; !st1 |-> $stable(pm_addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved mid cycle");
  property p_rd_first; pm_rd |-> st1; endproperty
  a_rd_first: assert property (p_rd_first) else $error("fetch outside first state");
  property p_done_first; instr_done |-> st1 && gap_reg[1:0] == 2'h0; endproperty
  a_done_first: assert property (p_done_first) else $error("partial machine cycle");
  property p_jmp3; instr_done && op3 |-> gap_reg == 5'h0C; endproperty
  a_jmp3: assert property (p_jmp3) else $error("short jump not 12 clocks");
  property p_jmp4; instr_done && op4 |-> gap_reg == 5'h10; endproperty
  a_jmp4: assert property (p_jmp4) else $error("long jump not 16 clocks");
  property p_xmov; instr_done && opx |-> gap_reg == 5'h08; endproperty
  a_xmov: assert property (p_xmov) else $error("external move not 8 clocks");
  property p_taken; branch_taken |-> instr_done && (op3 || op4); endproperty
  a_taken: assert property (p_taken) else $error("taken without branch");
  property p_bit_clr; bit_clr |-> cur_opcode == cbt_pkg::OP_JMP_BIT_CLR; endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("stray bit clear");
  property p_dir_wr; dir_wr |-> cur_opcode == 8'hD5 && dir_wdata == $past(dir_rdata) - 8'h01; endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("bad direct write");
  c_taken: cover property (branch_taken);
  c_bit_clr: cover property (bit_clr);
  c_dir_wr: cover property (dir_wr);
endmodule

bind cbt_core cbt_core_properties u_props
(
  .ref_clk, .rst_n, .pm_addr, .pm_rd, .dir_rdata, .bit_clr, .dir_wr, .dir_wdata,
  .machine_state, .cur_opcode, .instr_done, .branch_taken
);

`default_nettype wire

// [tb/cbt_pm_model.sv]
`timescale 1ns/10ps
`default_nettype none

module cbt_pm_model
(
  // Fetch port
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_rd,
  output logic      [7:0]  pm_data
);
  logic [7:0] mem [0:255];
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h08;
  end
  // Byte at the held address stays valid through the whole machine cycle
  assign pm_data = mem[pm_addr[7:0]];
endmodule

`default_nettype wire

// [tb/tb_cpu_branch_cycle_timing.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_cpu_branch_cycle_timing;
  typedef struct packed
  {
    logic [15:0] clks;
    logic [15:0] pc;
    logic        tk;
    logic [7:0]  oa;
    logic        oa_on;
    logic        bc;
    logic        dw;
    logic [7:0]  dwd;
  } cbt_note_type;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] pm_addr;
  logic        pm_rd, bit_clr, dir_wr, instr_done, branch_taken;
  logic [7:0]  pm_data, operand_addr, dir_wdata, cur_opcode;
  logic [7:0]  acc_data = 8'h00, dir_rdata = 8'h00, ind0_rdata = 8'h00, ind1_rdata = 8'h00;
  logic        carry_flag = 1'b0, bit_value = 1'b0;
  logic        got = 1'b0;
  cbt_pkg::cbt_mstate_type machine_state;
  cbt_note_type notes[$];
  cbt_note_type nt;
  int err_total = 0, num_checks = 0, cyc = 0, wd = 0;

  always #2.5 ref_clk = ~ref_clk;

  cbt_core dut
  (
    .ref_clk, .rst_n, .pm_addr, .pm_rd, .pm_data, .acc_data, .carry_flag, .bit_value,
    .dir_rdata, .ind0_rdata, .ind1_rdata, .operand_addr, .bit_clr, .dir_wr, .dir_wdata,
    .machine_state, .cur_opcode, .instr_done, .branch_taken
  );
  cbt_pm_model pm (.pm_addr, .pm_rd, .pm_data);

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
    num_checks++;
    if (act !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, act);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc <= (rst_n === 1'b1) ? cyc + 1 : 0;
    wd <= wd + 1;
    if (wd == 30000)
    begin
      err_total++;
      test_done();
    end
  end

  always @(negedge ref_clk)
  begin
    if (rst_n === 1'b1 && instr_done === 1'b1 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      chk("clocks", nt.clks, 16'(cyc));
      chk("next_pc", nt.pc, pm_addr);
      chk("taken", 16'(nt.tk), 16'(branch_taken));
      chk("bit_clr", 16'(nt.bc), 16'(bit_clr));
      chk("dir_wr", 16'(nt.dw), 16'(dir_wr));
      if (nt.dw)
        chk("dir_wdata", 16'(nt.dwd), 16'(dir_wdata));
      if (nt.oa_on)
        chk("operand_addr", 16'(nt.oa), 16'(operand_addr));
      got = 1'b1;
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  function automatic logic [2:0] mc_of(input logic [7:0] op);
    if (op inside {8'h80, 8'h60, 8'h70, 8'h40, 8'h50, [8'hD8:8'hDF]})
      return 3'h3;
    if (op inside {8'h20, 8'h30, 8'h10, [8'hB4:8'hBF], 8'hD5})
      return 3'h4;
    if (op inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3})
      return 3'h2;
    return op[3] ? 3'h1 : 3'h2;
  endfunction

  task automatic run_op(input logic [7:0] op);
    logic [7:0] a, dv, i0, i1, b1, rel, off;
    logic [2:0] mc;
    logic [1:0] len;
    logic       cy, bv, tk, ext;
    int         n;
    ext = op inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
    mc = mc_of(op);
    len = (mc > 3'h2) ? 2'(mc - 3'h1) : (ext ? 2'h1 : 2'(mc));
    b1 = (len == 2'h3) ? 8'($urandom_range(0, 2)) : 8'($urandom);
    rel = 8'($urandom);
    a = 8'($urandom_range(0, 2));
    dv = 8'($urandom_range(0, 2));
    i0 = 8'($urandom_range(0, 2));
    i1 = 8'($urandom_range(0, 2));
    cy = 1'($urandom);
    bv = 1'($urandom);
    case (op) inside
      8'h80: tk = 1'b1;
      8'h60: tk = a == 8'h00;
      8'h70: tk = a != 8'h00;
      8'h40: tk = cy;
      8'h50: tk = !cy;
      8'h20, 8'h10: tk = bv;
      8'h30: tk = !bv;
      8'hB5: tk = a != dv;
      8'hB4: tk = a != b1;
      8'hB6: tk = i0 != b1;
      8'hB7: tk = i1 != b1;
      [8'hB8:8'hBF]: tk = b1 != 8'h00;
      [8'hD8:8'hDF]: tk = 1'b1;
      8'hD5: tk = dv != 8'h01;
      default: tk = 1'b0;
    endcase
    off = (len == 2'h3) ? rel : b1;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    acc_data <= a;
    dir_rdata <= dv;
    ind0_rdata <= i0;
    ind1_rdata <= i1;
    carry_flag <= cy;
    bit_value <= bv;
    pm.mem[0] = op;
    pm.mem[1] = b1;
    pm.mem[2] = rel;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    got = 1'b0;
    notes.push_back('{16'(4 * mc), 16'(len) + (tk ? {{8{off[7]}}, off} : 16'h0000), tk,
                      b1, len != 2'h1, op == 8'h10 && tk, op == 8'hD5, 8'(dv - 8'h01)});
    n = 0;
    while (got !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (got !== 1'b1)
    begin
      chk("instr_done", 16'h0001, 16'h0000);
      notes.delete();
    end
  endtask

  initial
  begin
    void'($urandom(32'hC3F2C70F));
    repeat (16) @(posedge ref_clk);
    for (int p = 0; p < 2; p++)
    begin
      for (int op = 0; op < 256; op++)
        run_op(8'(op));
      $display("test opcode_sweep pass %0d done, mismatches %0d", p, err_total);
    end
    test_done();
  end
endmodule

`default_nettype wire
